/* pkg/ldtp_consts.vh */
// Constants for the lane detect and test pattern register bank.
// Included by the design files; definitions only.
`ifndef LDTP_CONSTS_VH
`define LDTP_CONSTS_VH

`define LDTP_ADDR_W          12
`define LDTP_OFF_EVEN_LANES  12'h200
`define LDTP_OFF_ODD_LANES   12'h204
`define LDTP_OFF_PAT_W0      12'h210
`define LDTP_OFF_PAT_W1      12'h214
`define LDTP_OFF_PAT_W2      12'h218
`define LDTP_OFF_PAT_W3      12'h21c
`define LDTP_OFF_PAT_MASK    12'hff0

`define LDTP_CMP_LSB         0
`define LDTP_EID_LSB         8
`define LDTP_RND_LSB         16
`define LDTP_RXD_LSB         24
`define LDTP_LANES_PER_REG   2

`define LDTP_CMP_RESET       2'h3
`define LDTP_EID_RESET       2'h0
`define LDTP_RND_RESET       2'h0
`define LDTP_PAT_RESET       32'h00000000

`define LDTP_PAT_WORDS       4
`define LDTP_PAT_BYTES       16
`define LDTP_BYTE_IDX_W      4

`endif

/* logic/ldtp_pattern_mem.v */
// Four-word user pattern store with a registered byte read port.
// Writes come from the register bank; the byte port feeds the transmitter.
`timescale 1ns/1ns
`include "ldtp_consts.vh"

module ldtp_pattern_mem #(
  parameter WORDS = `LDTP_PAT_WORDS
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  // Word write and read
  input  wire        wr_en_i,
  input  wire [1:0]  wr_idx_i,
  input  wire [31:0] wr_data_i,
  input  wire [1:0]  rd_idx_i,
  output reg  [31:0] rd_data_o,
  // Byte read for the transmitter
  input  wire [3:0]  byte_idx_i,
  output reg  [7:0]  byte_o
);

  reg [31:0] mem_q [0:WORDS-1];
  genvar g;

  generate
    for (g = 0; g < WORDS; g = g + 1)
    begin : g_word
      always @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          mem_q[g] <= `LDTP_PAT_RESET;
        else if (wr_en_i && wr_idx_i == g)
          mem_q[g] <= wr_data_i;
      end
    end
  endgenerate

  // Byte k lives in word k/4, lanes ascending, so bits 7:0 go first.
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= 32'h00000000;
      byte_o    <= 8'h00;
    end
    else
    begin
      rd_data_o <= mem_q[rd_idx_i];
      byte_o    <= mem_q[byte_idx_i[3:2]][byte_idx_i[1:0]*8 +: 8];
    end
  end

endmodule

/* logic/ldtp_top.v */
// Per-lane detect control/status and user test pattern registers.
// Assumes a simple same-clock register port, a sticky reset apart from the
// link reset, and LTSSM/SerDes logic on sys_clk_i.
`timescale 1ns/1ns
`include "ldtp_consts.vh"

module ldtp_top #(
  parameter LANES = 4
) (
  // Clock and resets
  input  wire             sys_clk_i,
  input  wire             rst_n_i,
  input  wire             link_rst_n_i,
  // Register port
  input  wire             reg_wr_i,
  input  wire             reg_rd_i,
  input  wire [11:0]      reg_addr_i,
  input  wire [31:0]      reg_wdata_i,
  output reg  [31:0]      reg_rdata_o,
  output reg              reg_rvalid_o,
  // Lane status from the SerDes and LTSSM
  input  wire [LANES-1:0] rx_found_i,
  input  wire [LANES-1:0] rx_found_vld_i,
  input  wire [LANES-1:0] idle_exit_seen_i,
  input  wire [LANES-1:0] infer_dis_i,
  input  wire             in_polling_active_i,
  // Lane controls to the SerDes and LTSSM
  output wire [LANES-1:0] analog_idle_en_o,
  output wire [LANES-1:0] idle_infer_en_o,
  output wire [LANES-1:0] rx_present_o,
  output wire             compliance_go_o,
  // Loopback and pattern transmit
  input  wire             loopback_cmd_i,
  input  wire             loopback_master_i,
  input  wire             pat_enable_i,
  output wire             loopback_req_o,
  output reg  [7:0]       tx_byte_o,
  output reg              tx_is_ctrl_o,
  output reg              tx_valid_o,
  input  wire             tx_ctrl_sel_i
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg  [LANES-1:0] cmp_mask_q;
  reg  [LANES-1:0] eid_mask_q;
  reg  [LANES-1:0] rnd_mask_q;
  reg  [LANES-1:0] rxd_q;
  reg  [LANES-1:0] exit_seen_q;
  reg              st_q;
  reg  [3:0]       idx_q;
  reg              send_q;
  reg              pat_rd_q;
  reg  [31:0]      rdata_q;
  wire [31:0]      pat_rdata;
  wire [7:0]       pat_byte;
  wire             pat_hit;
  wire             sending;
  wire [LANES-1:0] lane_ok;

  // Lane pair to register word; unused bit fields stay zero.
  function [31:0] pack_lanes;
    input [1:0] cmp;
    input [1:0] eid;
    input [1:0] rnd;
    input [1:0] rxd;
    begin
      pack_lanes = 32'h00000000;
      pack_lanes[`LDTP_CMP_LSB +: 2] = cmp;
      pack_lanes[`LDTP_EID_LSB +: 2] = eid;
      pack_lanes[`LDTP_RND_LSB +: 2] = rnd;
      pack_lanes[`LDTP_RXD_LSB +: 2] = rxd;
    end
  endfunction

  assign pat_hit = (reg_addr_i & `LDTP_OFF_PAT_MASK) == `LDTP_OFF_PAT_W0;

  // Masks live on the fundamental reset only, so a link reset keeps them.
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmp_mask_q <= {(LANES/2){`LDTP_CMP_RESET}};
      eid_mask_q <= {(LANES/2){`LDTP_EID_RESET}};
      rnd_mask_q <= {(LANES/2){`LDTP_RND_RESET}};
    end
    else if (reg_wr_i && reg_addr_i == `LDTP_OFF_EVEN_LANES)
    begin
      cmp_mask_q[1:0] <= reg_wdata_i[`LDTP_CMP_LSB +: 2];
      eid_mask_q[1:0] <= reg_wdata_i[`LDTP_EID_LSB +: 2];
      rnd_mask_q[1:0] <= reg_wdata_i[`LDTP_RND_LSB +: 2];
    end
    else if (reg_wr_i && reg_addr_i == `LDTP_OFF_ODD_LANES)
    begin
      cmp_mask_q[3:2] <= reg_wdata_i[`LDTP_CMP_LSB +: 2];
      eid_mask_q[3:2] <= reg_wdata_i[`LDTP_EID_LSB +: 2];
      rnd_mask_q[3:2] <= reg_wdata_i[`LDTP_RND_LSB +: 2];
    end
  end

  // Detect result follows the serializer; the idle-exit flag is per training pass.
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rxd_q       <= {LANES{1'b0}};
      exit_seen_q <= {LANES{1'b0}};
    end
    else if (!link_rst_n_i)
    begin
      exit_seen_q <= {LANES{1'b0}};
    end
    else
    begin
      rxd_q       <= (rxd_q & ~rx_found_vld_i) | (rx_found_i & rx_found_vld_i);
      if (in_polling_active_i)
        exit_seen_q <= exit_seen_q | idle_exit_seen_i;
      else
        exit_seen_q <= {LANES{1'b0}};
    end
  end

  assign analog_idle_en_o = ~eid_mask_q;
  assign idle_infer_en_o  = eid_mask_q & ~infer_dis_i;
  assign rx_present_o     = rxd_q | rnd_mask_q;
  assign lane_ok          = ~cmp_mask_q | (rx_present_o & ~exit_seen_q & ~idle_exit_seen_i);
  assign compliance_go_o  = in_polling_active_i && (|cmp_mask_q) && (&lane_ok);
  assign loopback_req_o   = loopback_cmd_i;
  assign sending          = pat_enable_i && loopback_master_i;

  // Register read, one cycle after the strobe.
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rvalid_o <= 1'b0;
      pat_rd_q     <= 1'b0;
      rdata_q      <= 32'h00000000;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      pat_rd_q     <= reg_rd_i && pat_hit;
      case (reg_addr_i)
        `LDTP_OFF_EVEN_LANES:
          rdata_q <= pack_lanes(cmp_mask_q[1:0], eid_mask_q[1:0], rnd_mask_q[1:0], rxd_q[1:0]);
        `LDTP_OFF_ODD_LANES:
          rdata_q <= pack_lanes(cmp_mask_q[3:2], eid_mask_q[3:2], rnd_mask_q[3:2], rxd_q[3:2]);
        default:
          rdata_q <= 32'h00000000;
      endcase
    end
  end

  ldtp_pattern_mem #(
    .WORDS      (`LDTP_PAT_WORDS)
  ) u_mem (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_en_i    (reg_wr_i && pat_hit),
    .wr_idx_i   (reg_addr_i[3:2]),
    .wr_data_i  (reg_wdata_i),
    .rd_idx_i   (reg_addr_i[3:2]),
    .rd_data_o  (pat_rdata),
    .byte_idx_i (idx_q),
    .byte_o     (pat_byte)
  );

  // Byte sequencer: 0..15 in order, wrapping while enabled.
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q   <= ST_IDLE;
      idx_q  <= 4'h0;
      send_q <= 1'b0;
    end
    else
    begin
      send_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          idx_q <= 4'h0;
          if (sending)
          begin
            st_q   <= ST_SEND;
            idx_q  <= 4'h1;
            send_q <= 1'b1;
          end
        end
        ST_SEND:
        begin
          if (!sending)
          begin
            st_q  <= ST_IDLE;
            idx_q <= 4'h0;
          end
          else
          begin
            idx_q  <= idx_q + 4'h1;
            send_q <= 1'b1;
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // The memory's byte port is one cycle behind idx_q, which starts at 1, so pat_byte and send_q already line up here.
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_byte_o    <= 8'h00;
      tx_is_ctrl_o <= 1'b0;
      tx_valid_o   <= 1'b0;
    end
    else
    begin
      tx_valid_o   <= send_q && sending;
      tx_byte_o    <= pat_byte;
      tx_is_ctrl_o <= tx_ctrl_sel_i;
    end
  end

  // A pattern read returns the memory word registered on the strobe cycle.
  // Both sources are flops loaded on the same edge, so only a select follows them.
  always @*
  begin
    reg_rdata_o = rdata_q;
    if (pat_rd_q)
      reg_rdata_o = pat_rdata;
  end

endmodule

/* tb/ldtp_top_props.sv */
// Checker for the lane detect and test pattern bank, on top-level ports only.
// Assumes one clock; bound into every ldtp_top instance below.
`timescale 1ns/1ns
module ldtp_top_chk #(
  parameter LANES = 4
) (
  input wire             sys_clk_i,
  input wire             rst_n_i,
  input wire             reg_wr_i,
  input wire             reg_rd_i,
  input wire [11:0]      reg_addr_i,
  input wire [31:0]      reg_wdata_i,
  input wire [31:0]      reg_rdata_o,
  input wire             reg_rvalid_o,
  input wire [LANES-1:0] idle_exit_seen_i,
  input wire [LANES-1:0] infer_dis_i,
  input wire [LANES-1:0] analog_idle_en_o,
  input wire [LANES-1:0] idle_infer_en_o,
  input wire [LANES-1:0] rx_present_o,
  input wire             compliance_go_o,
  input wire             loopback_cmd_i,
  input wire             loopback_req_o,
  input wire             pat_enable_i,
  input wire             loopback_master_i,
  input wire             tx_valid_o,
  input wire             tx_is_ctrl_o,
  input wire             tx_ctrl_sel_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of the compliance masks, so the gate can be judged from the ports.
  reg [3:0] cm_q;
  always @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i) cm_q <= 4'hf;
    else if (reg_wr_i && reg_addr_i == 12'h200) cm_q[1:0] <= reg_wdata_i[1:0];
    else if (reg_wr_i && reg_addr_i == 12'h204) cm_q[3:2] <= reg_wdata_i[1:0];
  wire en = pat_enable_i && loopback_master_i;
  property p_rv; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read gave no valid");
  property p_rsv; reg_rd_i && (reg_addr_i & 12'hffb) == 12'h200
    |=> (reg_rdata_o & 32'hfcfcfcfc) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_an; reg_wr_i && reg_addr_i == 12'h200 |=> analog_idle_en_o[1:0] == ~$past(reg_wdata_i[9:8]); endproperty
  a_an: assert property (p_an) else $error("analog idle enable wrong");
  property p_inf; (idle_infer_en_o & (infer_dis_i | analog_idle_en_o)) == 4'h0; endproperty
  a_inf: assert property (p_inf) else $error("inference enabled wrongly");
  property p_rnd; reg_wr_i && reg_addr_i == 12'h204 && reg_wdata_i[17] |=> rx_present_o[3]; endproperty
  a_rnd: assert property (p_rnd) else $error("forced receiver missing");
  property p_cgo; compliance_go_o |-> cm_q != 4'h0 && (cm_q & (idle_exit_seen_i | ~rx_present_o)) == 4'h0; endproperty
  a_cgo: assert property (p_cgo) else $error("compliance entry not allowed");
  property p_lb; loopback_req_o == loopback_cmd_i; endproperty
  a_lb: assert property (p_lb) else $error("loopback request differs");
  property p_st; $rose(en) ##1 en |-> !tx_valid_o ##1 tx_valid_o; endproperty
  a_st: assert property (p_st) else $error("pattern did not start");
  property p_sp; !en [*2] |=> !tx_valid_o; endproperty
  a_sp: assert property (p_sp) else $error("pattern sent while off");
  property p_ct; tx_valid_o |-> tx_is_ctrl_o == $past(tx_ctrl_sel_i); endproperty
  a_ct: assert property (p_ct) else $error("control flag wrong");
endmodule
bind ldtp_top ldtp_top_chk #(.LANES(LANES)) u_chk (.sys_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .idle_exit_seen_i, .infer_dis_i, .analog_idle_en_o,
  .idle_infer_en_o, .rx_present_o, .compliance_go_o, .loopback_cmd_i, .loopback_req_o, .pat_enable_i,
  .loopback_master_i, .tx_valid_o, .tx_is_ctrl_o, .tx_ctrl_sel_i);

/* tb/ldtp_link_partner.sv */
// Link partner model: presents terminations and collects the pattern stream.
// Assumes the transmit byte port is sampled on the core clock.
`timescale 1ns/1ns
module ldtp_link_partner (
  input  wire       sys_clk_i,
  input  wire [3:0] term_i,
  input  wire [7:0] tx_byte_i,
  input  wire       tx_valid_i,
  input  wire       tx_is_ctrl_i,
  output wire [3:0] rx_term_o
);
  reg [7:0] got [$];
  reg       ctl [$];
  assign rx_term_o = term_i;
  // Any code is taken, illegal control characters too.
  always @(posedge sys_clk_i)
    if (tx_valid_i)
    begin
      got.push_back(tx_byte_i);
      ctl.push_back(tx_is_ctrl_i);
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the lane detect and test pattern bank.
// Assumes ldtp_top, its checker and the link partner model are compiled first.
`timescale 1ns/1ns
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  reg        sys_clk_i = 0, rst_n_i = 0, link_rst_n_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  reg        in_polling_active_i = 0, loopback_cmd_i = 0, loopback_master_i = 0;
  reg        pat_enable_i = 0, tx_ctrl_sel_i = 0;
  reg [11:0] reg_addr_i = 0;
  reg [31:0] reg_wdata_i = 0;
  reg [3:0]  rx_found_vld_i = 0, idle_exit_seen_i = 0, infer_dis_i = 0, term = 0, st, em;
  wire [3:0] rx_found_i, analog_idle_en_o, idle_infer_en_o, rx_present_o;
  wire [31:0] reg_rdata_o;
  wire [7:0] tx_byte_o;
  wire       reg_rvalid_o, compliance_go_o, loopback_req_o, tx_is_ctrl_o, tx_valid_o;
  int        err_total = 0, num_checks = 0, cyc = 0, k, p;
  reg [31:0] pat [4];
  reg [31:0] m [2];
  always #4 sys_clk_i = ~sys_clk_i;
  ldtp_top #(.LANES(4)) DUT (.sys_clk_i, .rst_n_i, .link_rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .rx_found_i, .rx_found_vld_i, .idle_exit_seen_i,
    .infer_dis_i, .in_polling_active_i, .analog_idle_en_o, .idle_infer_en_o, .rx_present_o,
    .compliance_go_o, .loopback_cmd_i, .loopback_master_i, .pat_enable_i, .loopback_req_o,
    .tx_byte_o, .tx_is_ctrl_o, .tx_valid_o, .tx_ctrl_sel_i);
  ldtp_link_partner P (.sys_clk_i, .term_i(term), .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
    .tx_is_ctrl_i(tx_is_ctrl_o), .rx_term_o(rx_found_i));
  function [31:0] rexp(input [31:0] w, input [1:0] s);
    rexp = (w & 32'h00030303) | {6'h0, s, 24'h0};
  endfunction
  task finish_test;
  begin
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
  begin
    @(posedge sys_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge sys_clk_i) reg_wr_i <= 1'b0;
  end
  endtask
  task rd(input [11:0] a, input [31:0] e);
  begin
    @(posedge sys_clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge sys_clk_i) reg_rd_i <= 1'b0;
    @(negedge sys_clk_i) `CHK("rvalid", 1'b1, reg_rvalid_o)
    `CHK("rdata", e, reg_rdata_o)
  end
  endtask
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test;
    end
  end
  initial
  begin
    k = $urandom(32'hb83f);
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(12'h200, 32'h3);
    rd(12'h204, 32'h3);
    rd(12'h208, 32'h0);
    rd(12'h21c, 32'h0);
    for (k = 0; k < 24; k++)
    begin
      @(posedge sys_clk_i) {term, infer_dis_i, idle_exit_seen_i} <= $urandom;
      in_polling_active_i <= $urandom;
      @(posedge sys_clk_i) rx_found_vld_i <= 4'hf;
      @(posedge sys_clk_i) rx_found_vld_i <= 4'h0;
      st = term;
      m[0] = (k == 5) ? 32'h0 : $urandom;
      m[1] = (k == 5) ? 32'h0 : $urandom;
      wr(12'h200, m[0]);
      wr(12'h204, m[1]);
      rd(12'h200, rexp(m[0], st[1:0]));
      rd(12'h204, rexp(m[1], st[3:2]));
      em = {m[1][9:8], m[0][9:8]};
      `CHK("analog", ~em, analog_idle_en_o)
      `CHK("infer", em & ~infer_dis_i, idle_infer_en_o)
      `CHK("present", st | {m[1][17:16], m[0][17:16]}, rx_present_o)
      if (k == 5) `CHK("comply", 1'b0, compliance_go_o)
    end
    @(posedge sys_clk_i) link_rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    link_rst_n_i <= 1'b1;
    rd(12'h204, rexp(m[1], st[3:2]));
    for (p = 0; p < 2; p++)
    begin
      for (k = 0; k < 4; k++)
        pat[k] = p ? $urandom : 32'h0;
      for (k = 0; p && k < 4; k++)
        wr(12'h210 + 12'(4 * k), pat[k]);
      for (k = 0; k < 4; k++)
        rd(12'h210 + 12'(4 * k), pat[k]);
      @(posedge sys_clk_i) {loopback_cmd_i, tx_ctrl_sel_i, loopback_master_i} <= {1'b1, p[0], 1'b1};
      @(negedge sys_clk_i) `CHK("loopreq", 1'b1, loopback_req_o)
      P.got.delete();
      P.ctl.delete();
      @(posedge sys_clk_i) pat_enable_i <= 1'b1;
      for (k = 0; k < 200 && P.got.size() < 32; k++)
        @(posedge sys_clk_i);
      pat_enable_i <= 1'b0;
      for (k = 0; k < 32; k++)
        `CHK("txbyte", pat[(k % 16) / 4][8 * (k % 4) +: 8], P.got[k])
      `CHK("txctrl", p[0], P.ctl[0])
      repeat (3) @(posedge sys_clk_i);
      @(negedge sys_clk_i) `CHK("txoff", 1'b0, tx_valid_o)
    end
    finish_test;
  end
endmodule
